// [rtl/rrse_exec.sv]
// Executor for rotate right through carry and the sleep instruction.
// Assumes an instruction strobe from the core; wake-up comes from outside.
// Summary of operation
// - Rotate right: old carry into bit 7, old bit 0 becomes carry.
// - Destination bit 0 writes working register, 1 writes the file register.
// - Sleep sets time-out flag, clears power-down flag, watchdog counter and prescaler.
// - Sleep stops oscillator and suspends execution until wake-up.
`default_nettype none
module rrse_exec
	import rrse_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               sys_rst,
	input  wire logic               instrValid,
	input  wire logic [INSTR_W-1:0] instrWord,
	input  wire logic               wakeEvent,
	input  wire logic               watchdogTick,
	output logic      [DATA_W-1:0]  workReg,
	output logic                    carryFlag,
	output logic                    timeoutFlag,
	output logic                    powerdownFlag,
	output logic      [7:0]         watchdogCounter,
	output logic      [7:0]         watchdogPrescaler,
	output logic                    oscRunning,
	output logic                    execBusy
);
	typedef enum logic [1:0] {
		RRSE_IDLE  = 2'b00,
		RRSE_READ  = 2'b01,
		RRSE_WRITE = 2'b10,
		RRSE_SLEEP = 2'b11
	} rrse_state_e;

	rrse_state_e state, next_state;
	logic [ADDR_W-1:0] addr, next_addr;
	logic dest, next_dest;
	logic [DATA_W-1:0] next_workReg;
	logic next_carryFlag, next_timeoutFlag, next_powerdownFlag;
	logic [7:0] next_watchdogCounter, next_watchdogPrescaler;
	logic next_oscRunning, next_execBusy;
	logic [DATA_W-1:0] ramRd, rotated;
	logic ramWe;

	function automatic logic is_rotate(input logic [INSTR_W-1:0] w);
		return w[INSTR_W-1:OPC_HI+1] == 2'h0 && w[OPC_HI:OPC_LO] == ROTATE_RIGHT_CARRY_OP;
	endfunction

	function automatic logic is_sleep(input logic [INSTR_W-1:0] w);
		return w == SLEEP_WORD;
	endfunction

	rrse_file_ram #(.DW(DATA_W), .AW(ADDR_W)) u_ram (
		.sys_clk (sys_clk),
		.wrEn    (ramWe),
		.wrAddr  (addr),
		.wrData  (rotated),
		.rdAddr  (next_addr),
		.rdData  (ramRd)
	);

	assign rotated = {carryFlag, ramRd[DATA_W-1:1]};
	assign ramWe = (state == RRSE_READ) && dest;

	always_comb begin
		next_state = state;
		next_addr = addr;
		next_dest = dest;
		next_workReg = workReg;
		next_carryFlag = carryFlag;
		next_timeoutFlag = timeoutFlag;
		next_powerdownFlag = powerdownFlag;
		next_watchdogCounter = watchdogCounter;
		next_watchdogPrescaler = watchdogPrescaler;
		next_oscRunning = oscRunning;
		next_execBusy = execBusy;
		// Watchdog keeps counting while awake only
		if (watchdogTick && oscRunning) begin
			next_watchdogPrescaler = watchdogPrescaler + 8'h01;
			if (watchdogPrescaler == 8'hFF) begin
				next_watchdogCounter = watchdogCounter + 8'h01;
			end
		end
		case (state)
			RRSE_IDLE: begin
				next_execBusy = 1'b0;
				if (instrValid) begin
					if (is_rotate(instrWord)) begin
						next_addr = instrWord[ADDR_W-1:0];
						next_dest = instrWord[DEST_BIT];
						next_state = RRSE_READ;
						next_execBusy = 1'b1;
					end else if (is_sleep(instrWord)) begin
						next_timeoutFlag = 1'b1;
						next_powerdownFlag = 1'b0;
						next_watchdogCounter = WATCHDOG_CLEAR;
						next_watchdogPrescaler = PRESCALE_CLEAR;
						next_oscRunning = 1'b0;
						next_execBusy = 1'b1;
						next_state = RRSE_SLEEP;
					end
				end
			end
			RRSE_READ: begin
				next_carryFlag = ramRd[0];
				if (!dest) begin
					next_workReg = rotated;
				end
				next_state = RRSE_WRITE;
			end
			RRSE_WRITE: begin
				next_execBusy = 1'b0;
				next_state = RRSE_IDLE;
			end
			RRSE_SLEEP: begin
				if (wakeEvent) begin
					next_oscRunning = 1'b1;
					next_execBusy = 1'b0;
					next_state = RRSE_IDLE;
				end
			end
			default: next_state = RRSE_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= RRSE_IDLE;
			addr <= '0;
			dest <= 1'b0;
			workReg <= WREG_RESET;
			carryFlag <= CARRY_RESET;
			timeoutFlag <= TIMEOUT_RESET;
			powerdownFlag <= POWERDOWN_RESET;
			watchdogCounter <= WATCHDOG_CLEAR;
			watchdogPrescaler <= PRESCALE_CLEAR;
			oscRunning <= 1'b1;
			execBusy <= 1'b0;
		end else begin
			state <= next_state;
			addr <= next_addr;
			dest <= next_dest;
			workReg <= next_workReg;
			carryFlag <= next_carryFlag;
			timeoutFlag <= next_timeoutFlag;
			powerdownFlag <= next_powerdownFlag;
			watchdogCounter <= next_watchdogCounter;
			watchdogPrescaler <= next_watchdogPrescaler;
			oscRunning <= next_oscRunning;
			execBusy <= next_execBusy;
		end
	end

	property p_rot_carry;
		@(posedge sys_clk) disable iff (sys_rst)
		(state == RRSE_READ) |=> carryFlag == $past(ramRd[0]);
	endproperty
	a_rot_carry: assert property (p_rot_carry) else $error("carry not old bit 0");

	property p_rot_w;
		@(posedge sys_clk) disable iff (sys_rst)
		(state == RRSE_READ && !dest) |=> workReg == {$past(carryFlag), $past(ramRd[7:1])};
	endproperty
	a_rot_w: assert property (p_rot_w) else $error("working register rotate wrong");

	property p_dest_f;
		@(posedge sys_clk) disable iff (sys_rst)
		(state == RRSE_READ && dest) |=> $stable(workReg);
	endproperty
	a_dest_f: assert property (p_dest_f) else $error("file destination touched W");

	property p_sleep_flags;
		@(posedge sys_clk) disable iff (sys_rst)
		(state == RRSE_IDLE && instrValid && instrWord == SLEEP_WORD)
			|=> timeoutFlag && !powerdownFlag && $stable(carryFlag);
	endproperty
	a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");

	property p_sleep_wdt;
		@(posedge sys_clk) disable iff (sys_rst)
		(state == RRSE_IDLE && instrValid && instrWord == SLEEP_WORD)
			|=> watchdogCounter == 8'h00 && watchdogPrescaler == 8'h00;
	endproperty
	a_sleep_wdt: assert property (p_sleep_wdt) else $error("watchdog not cleared");

	property p_sleep_osc;
		@(posedge sys_clk) disable iff (sys_rst)
		(state == RRSE_SLEEP && !wakeEvent) |=> !oscRunning && execBusy;
	endproperty
	a_sleep_osc: assert property (p_sleep_osc) else $error("sleep left early");

	property p_rot_len;
		@(posedge sys_clk) disable iff (sys_rst)
		(state == RRSE_IDLE && instrValid && is_rotate(instrWord))
			|=> execBusy ##1 execBusy ##1 !execBusy;
	endproperty
	a_rot_len: assert property (p_rot_len) else $error("rotate length wrong");

	property p_wake;
		@(posedge sys_clk) disable iff (sys_rst)
		(state == RRSE_SLEEP && wakeEvent) |=> oscRunning && !execBusy && state == RRSE_IDLE;
	endproperty
	a_wake: assert property (p_wake) else $error("wake not taken");

	// Halted oscillator must leave the watchdog untouched
	property p_osc_freeze;
		@(posedge sys_clk) disable iff (sys_rst)
		!oscRunning |=> $stable(watchdogPrescaler) && $stable(watchdogCounter);
	endproperty
	a_osc_freeze: assert property (p_osc_freeze) else $error("watchdog moved while halted");
endmodule
`default_nettype wire

// [rtl/rrse_file_ram.sv]
// Small file register memory with registered read data.
// Assumes one read and one write port on the core clock.
`default_nettype none
module rrse_file_ram
	import rrse_pkg::*;
#(
	parameter int DW = DATA_W,
	parameter int AW = ADDR_W
) (
	input  wire logic          sys_clk,
	input  wire logic          wrEn,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [DW-1:0] wrData,
	input  wire logic [AW-1:0] rdAddr,
	output logic      [DW-1:0] rdData
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Rotation needs two data bits at least
	if (DW < 2 || AW < 1) begin : g_size_check
		$error("memory size not supported");
	end

	// Each word starts as its own address: rotates never act on unknown data
	initial begin
		for (int i = 0; i < (1 << AW); i++) begin
			mem[i] = DW'(i);
		end
	end

	// Plain always, since the power-up load also writes the array
	always @(posedge sys_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdData <= mem[rdAddr];
	end
endmodule
`default_nettype wire

// [shared/rrse_pkg.sv]
// Constants for the rotate-right-through-carry and sleep executor.
// Assumes a 14-bit instruction word presented by the core fetch logic.
`default_nettype none
package rrse_pkg;
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam logic [3:0] ROTATE_RIGHT_CARRY_OP = 4'hC;
	localparam int OPC_HI = 11;
	localparam int OPC_LO = 8;
	localparam int DEST_BIT = 7;
	localparam logic [13:0] SLEEP_WORD = 14'h0063;
	localparam logic [7:0] WATCHDOG_CLEAR = 8'h00;
	localparam logic [7:0] PRESCALE_CLEAR = 8'h00;
	localparam logic [7:0] WREG_RESET = 8'h00;
	localparam logic TIMEOUT_RESET = 1'b1;
	localparam logic POWERDOWN_RESET = 1'b1;
	localparam logic CARRY_RESET = 1'b0;
endpackage
`default_nettype wire

// [testbench/rrse_exec_tb.sv]
// Self-checking bench for the rotate-right and sleep executor.
// Assumes the executor alone; inputs change at falling clock edges.
`default_nettype none
module rrse_exec_tb
	import rrse_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic               sys_clk = 1'b0;
	logic               sys_rst = 1'b1;
	logic               instrValid = 1'b0;
	logic [INSTR_W-1:0] instrWord = '0;
	logic               wakeEvent = 1'b0;
	logic               watchdogTick = 1'b0;
	logic [DATA_W-1:0]  workReg;
	logic               carryFlag, timeoutFlag, powerdownFlag, oscRunning, execBusy;
	logic [7:0]         watchdogCounter, watchdogPrescaler;
	int                 errorCnt = 0;
	int                 numChecks = 0;
	int                 cycles = 0;
	rrse_exec uut (.sys_clk, .sys_rst, .instrValid, .instrWord, .wakeEvent, .watchdogTick,
		.workReg, .carryFlag, .timeoutFlag, .powerdownFlag, .watchdogCounter,
		.watchdogPrescaler, .oscRunning, .execBusy);
	always #25 sys_clk = ~sys_clk;
	// Whole run needs about 550 cycles
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errorCnt++;
			testDone();
		end
	end
	task automatic testDone();
		$display("checks %0d mismatches %0d", numChecks, errorCnt);
		if (errorCnt == 0 && numChecks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		numChecks++;
		if (seen !== exp) begin
			errorCnt++;
			$display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic issue(input logic [INSTR_W-1:0] w);
		@(negedge sys_clk);
		instrValid = 1'b1;
		instrWord = w;
		@(negedge sys_clk);
		instrValid = 1'b0;
	endtask
	task automatic pulse(ref logic s);
		@(negedge sys_clk);
		s = 1'b1;
		@(negedge sys_clk);
		s = 1'b0;
	endtask
	task automatic t_reset();
		chk({timeoutFlag, powerdownFlag, carryFlag, oscRunning, execBusy}, 8'h1A, "reset flags");
		chk(workReg, WREG_RESET, "reset work");
		$display("reset test done");
	endtask
	task automatic t_sleep();
		// One prescaler wrap, then three more ticks
		repeat (259) pulse(watchdogTick);
		chk(watchdogCounter, 8'h01, "counter from prescaler wrap");
		chk(watchdogPrescaler, 8'h03, "prescaler ticks");
		issue(SLEEP_WORD);
		chk(timeoutFlag, 1'b1, "timeout set");
		chk(powerdownFlag, 1'b0, "powerdown clear");
		chk(carryFlag, 1'b0, "carry kept");
		chk(watchdogCounter, WATCHDOG_CLEAR, "wdt clear");
		chk(watchdogPrescaler, PRESCALE_CLEAR, "prescaler clear");
		chk({oscRunning, execBusy}, 8'h01, "asleep");
		// Stopped oscillator must freeze the prescaler
		pulse(watchdogTick);
		chk(watchdogPrescaler, 8'h00, "frozen in sleep");
		issue({2'b00, ROTATE_RIGHT_CARRY_OP, 1'b0, 7'h05});
		repeat (2) @(negedge sys_clk);
		chk(workReg, 8'h00, "no execution asleep");
		pulse(wakeEvent);
		chk({oscRunning, execBusy}, 8'h02, "awake");
		chk({timeoutFlag, powerdownFlag}, 8'h02, "flags held");
		$display("sleep test done");
	endtask
	task automatic settle();
		int n;
		n = 0;
		while (execBusy !== 1'b0 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		chk(execBusy, 1'b0, "idle again");
	endtask
	task automatic t_rotate();
		// File word 5 starts as 8'h05; carry is 0 after the sleep test
		issue({2'b00, ROTATE_RIGHT_CARRY_OP, 1'b0, 7'h05});
		chk(execBusy, 1'b1, "rotate busy");
		settle();
		chk(workReg[7], 1'b0, "old carry to bit 7");
		chk(workReg, 8'h02, "rotated into W");
		chk(carryFlag, 1'b1, "old bit 0 to carry");
		issue({2'b00, ROTATE_RIGHT_CARRY_OP, 1'b1, 7'h05});
		settle();
		chk(workReg, 8'h02, "file destination");
		chk(carryFlag, 1'b1, "carry from file rotate");
		// Word 5 should now hold 8'h82; read it back through W
		issue({2'b00, ROTATE_RIGHT_CARRY_OP, 1'b0, 7'h05});
		settle();
		chk(workReg, 8'hC1, "file word written back");
		chk(carryFlag, 1'b0, "carry from written word");
		issue({2'b00, 4'hD, 1'b0, 7'h05});
		chk(execBusy, 1'b0, "other opcode ignored");
		chk(workReg, 8'hC1, "other opcode no write");
		$display("rotate test done");
	endtask
	initial begin
		repeat (2) @(negedge sys_clk);
		sys_rst = 1'b0;
		t_reset();
		t_sleep();
		t_rotate();
		testDone();
	end
endmodule
`default_nettype wire
